// ---- src/amx_map.svh ----
// field positions, codes and reset values of the converter configuration word
// assumes inclusion by the package and by the sequencer module
`ifndef AMX_MAP_SVH
`define AMX_MAP_SVH
`define AMX_CFG_W         14
`define AMX_CFG_RESET     14'h3fff
`define AMX_BIT_UPDATE    13
`define AMX_INC_HI        12
`define AMX_INC_LO        10
`define AMX_INC_SINGLE    11
`define AMX_INC_UNIPOLAR  12
`define AMX_CH_HI         9
`define AMX_CH_LO         7
`define AMX_BIT_BW        6
`define AMX_REF_HI        5
`define AMX_REF_LO        3
`define AMX_SEQ_HI        2
`define AMX_SEQ_LO        1
`define AMX_BIT_READBACK  0
`define AMX_SEQ_OFF       2'h0
`define AMX_SEQ_UPDATE    2'h1
`define AMX_SEQ_SCAN_TEMP 2'h2
`define AMX_SEQ_SCAN      2'h3
`define AMX_INC_GND       3'h7
`define AMX_INC_BI_COM    3'h2
`define AMX_INC_UNI_COM   3'h6
`define AMX_INC_BI_COM_X  3'h3
`define AMX_PAIR_FLIP     3'h1
`define AMX_RES_MSB       15
`define AMX_CONV_IDLE     1'b1
`define AMX_LAST_BIT      5'hd
`define AMX_CH_ZERO       3'h0
`define AMX_CH_STEP_PAIR  3'h2
`define AMX_CH_STEP_ONE   3'h1
`endif

// ---- src/amx_pkg.sv ----
// types shared by the input mux sequencer
// assumes the map header is on the include path
`include "amx_map.svh"
package amx_pkg;
  typedef enum logic [1:0] {
    AMX_NEG_GND,
    AMX_NEG_COM,
    AMX_NEG_CHANNEL
  } amx_neg_t;

  typedef struct packed {
    logic [2:0] pos_ch;
    logic [2:0] neg_ch;
    amx_neg_t   neg_kind;
    logic       temp_sensor;
    logic       bipolar;
    logic       quarter_bw;
  } amx_mux_t;

  typedef struct packed {
    logic [15:0] data;
    logic        valid;
  } amx_result_t;
endpackage : amx_pkg

// ---- src/amx_sequencer.sv ----
// configuration capture, channel sequencer and result coding of the input mux
// assumes SCK, DIN and convert start arrive from pins; raw core results come on I_CLOCK, offset binary
//
// Overview of operation
// - bipolar arrangement gives twos complement results
// - one bit picks full or quarter bandwidth
// - arrangement 111 is single-ended against ground
// - 010 bipolar common, 110 unipolar common
// - 00X bipolar pairs, 10X unipolar pairs
// - paired mode channel field names positive input
// - scan runs input 0 to last channel
// - scanned pairs always even positive, odd negative
// - scan singles or pairs, optional temperature last
// - sequencer code 10 or 11 write initialises and starts scan
// - sequencer code 01 updates without stopping scan
// - single/pair change or last-channel change restarts scan
// - arrangement may change from conversion to conversion
// - word captured on first fourteen clock rises
// - unipolar arrangements give straight binary results
`timescale 1ns/100ps
`include "amx_map.svh"
module amx_sequencer
  import amx_pkg::*;
(
  input  wire logic                  I_CLOCK,
  input  wire logic                  I_RESET,
  input  wire logic                  I_SCK,
  input  wire logic                  I_DIN,
  input  wire logic                  I_CONVERT,
  input  wire logic [15:0]           I_RAW_DATA,
  input  wire logic                  I_RAW_VALID,
  output logic      [`AMX_CFG_W-1:0] O_CFG_WORD,
  output logic                       O_READBACK_EN,
  output logic                       O_SCAN_ACTIVE,
  output amx_mux_t                   O_MUX,
  output logic                       O_CONV_START,
  output amx_result_t                O_RESULT
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers, three stages, level moves when stages two and three agree
  logic [2:0] sck_s_q;
  logic [2:0] din_s_q;
  logic [2:0] conv_s_q;
  logic       sck_q;
  logic       din_q;
  logic       conv_q;
  logic       sck_prev_q;
  logic       conv_prev_q;

  // convert path leaves reset at its idle level, so no false start follows reset
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      sck_s_q  <= 3'h0;
      din_s_q  <= 3'h0;
      conv_s_q <= {3{`AMX_CONV_IDLE}};
    end else begin
      sck_s_q  <= {sck_s_q[1:0], I_SCK};
      din_s_q  <= {din_s_q[1:0], I_DIN};
      conv_s_q <= {conv_s_q[1:0], I_CONVERT};
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      sck_q       <= 1'b0;
      din_q       <= 1'b0;
      conv_q      <= `AMX_CONV_IDLE;
      sck_prev_q  <= 1'b0;
      conv_prev_q <= `AMX_CONV_IDLE;
    end else begin
      if (sck_s_q[1] == sck_s_q[2]) sck_q <= sck_s_q[2];
      if (din_s_q[1] == din_s_q[2]) din_q <= din_s_q[2];
      if (conv_s_q[1] == conv_s_q[2]) conv_q <= conv_s_q[2];
      sck_prev_q  <= sck_q;
      conv_prev_q <= conv_q;
    end
  end

  logic sck_rise;
  logic conv_rise;
  assign sck_rise  = sck_q & ~sck_prev_q;
  assign conv_rise = conv_q & ~conv_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // serial capture of the configuration word
  logic [`AMX_CFG_W-1:0] shift_q;
  logic [4:0]            bit_cnt_q;
  logic                  commit;

  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      shift_q   <= '0;
      bit_cnt_q <= 5'h0;
    end else if (conv_q) begin
      bit_cnt_q <= 5'h0;
    end else if (sck_rise && bit_cnt_q <= `AMX_LAST_BIT) begin
      shift_q   <= {shift_q[`AMX_CFG_W-2:0], din_q};
      bit_cnt_q <= bit_cnt_q + 5'h1;
    end
  end

  // first bit is the update flag; low first bit leaves the word untouched
  assign commit = !conv_q && sck_rise && bit_cnt_q == `AMX_LAST_BIT
                  && shift_q[`AMX_BIT_UPDATE-1];

  logic [`AMX_CFG_W-1:0] new_word;
  assign new_word = {shift_q[`AMX_CFG_W-2:0], din_q};

  ////////////////////////////////////////////////////////////////////////////
  // configuration register and scan control
  logic [`AMX_CFG_W-1:0] cfg_q;
  logic [1:0]            scan_mode_q;
  logic                  scan_on_q;
  logic                  restart;

  function automatic logic is_single(input logic [`AMX_CFG_W-1:0] w);
    is_single = w[`AMX_INC_SINGLE];
  endfunction : is_single

  function automatic logic [1:0] seq_of(input logic [`AMX_CFG_W-1:0] w);
    seq_of = w[`AMX_SEQ_HI:`AMX_SEQ_LO];
  endfunction : seq_of

  assign restart = commit && seq_of(new_word) == `AMX_SEQ_UPDATE && scan_on_q
                   && (is_single(new_word) != is_single(cfg_q)
                       || new_word[`AMX_CH_HI:`AMX_CH_LO] != cfg_q[`AMX_CH_HI:`AMX_CH_LO]);

  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      cfg_q       <= `AMX_CFG_RESET;
      scan_mode_q <= `AMX_SEQ_OFF;
      scan_on_q   <= 1'b0;
    end else if (commit) begin
      cfg_q <= new_word;
      if (seq_of(new_word) != `AMX_SEQ_UPDATE) begin
        scan_mode_q <= seq_of(new_word);
        scan_on_q   <= new_word[`AMX_SEQ_HI];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // scan pointer and mux selection per conversion
  logic [2:0] ptr_q;
  logic       temp_step_q;
  logic [2:0] last_ch;
  logic       single;
  logic       bipolar;
  logic [2:0] step;
  logic       at_last;

  assign single  = is_single(cfg_q);
  assign bipolar = ~cfg_q[`AMX_INC_UNIPOLAR];
  assign last_ch = single ? cfg_q[`AMX_CH_HI:`AMX_CH_LO]
                          : {cfg_q[`AMX_CH_HI:`AMX_CH_LO+1], 1'b0};
  assign step    = single ? `AMX_CH_STEP_ONE : `AMX_CH_STEP_PAIR;
  assign at_last = ptr_q == last_ch;

  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      ptr_q       <= `AMX_CH_ZERO;
      temp_step_q <= 1'b0;
    end else if ((commit && seq_of(new_word) != `AMX_SEQ_UPDATE) || restart) begin
      ptr_q       <= `AMX_CH_ZERO;
      temp_step_q <= 1'b0;
    end else if (conv_rise && scan_on_q) begin
      if (temp_step_q) begin
        ptr_q       <= `AMX_CH_ZERO;
        temp_step_q <= 1'b0;
      end else if (at_last) begin
        ptr_q       <= `AMX_CH_ZERO;
        temp_step_q <= scan_mode_q == `AMX_SEQ_SCAN_TEMP;
      end else begin
        ptr_q <= ptr_q + step;
      end
    end
  end

  amx_mux_t mux_d;
  logic [2:0] pos_ch;

  always_comb begin
    pos_ch = scan_on_q ? ptr_q : cfg_q[`AMX_CH_HI:`AMX_CH_LO];
    mux_d.pos_ch      = pos_ch;
    mux_d.neg_ch      = pos_ch ^ `AMX_PAIR_FLIP;
    mux_d.temp_sensor = scan_on_q && temp_step_q;
    mux_d.bipolar     = bipolar;
    mux_d.quarter_bw  = ~cfg_q[`AMX_BIT_BW];
    case (cfg_q[`AMX_INC_HI:`AMX_INC_LO])
      `AMX_INC_GND: mux_d.neg_kind = AMX_NEG_GND;
      `AMX_INC_BI_COM, `AMX_INC_UNI_COM: mux_d.neg_kind = AMX_NEG_COM;
      `AMX_INC_BI_COM_X:                 mux_d.neg_kind = AMX_NEG_COM;
      default:      mux_d.neg_kind = AMX_NEG_CHANNEL;
    endcase
    if (mux_d.temp_sensor) begin
      mux_d.neg_kind = AMX_NEG_GND;
      mux_d.bipolar  = 1'b0;
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      O_MUX        <= '0;
      O_CONV_START <= 1'b0;
    end else begin
      O_CONV_START <= conv_rise;
      if (conv_rise) O_MUX <= mux_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // result coding and status outputs
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      O_RESULT <= '0;
    end else begin
      O_RESULT.valid <= I_RAW_VALID;
      if (I_RAW_VALID) begin
        O_RESULT.data <= O_MUX.bipolar ? {~I_RAW_DATA[`AMX_RES_MSB], I_RAW_DATA[`AMX_RES_MSB-1:0]}
                                       : I_RAW_DATA;
      end
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      O_CFG_WORD    <= `AMX_CFG_RESET;
      O_READBACK_EN <= 1'b0;
      O_SCAN_ACTIVE <= 1'b0;
    end else begin
      O_CFG_WORD    <= cfg_q;
      O_READBACK_EN <= cfg_q[`AMX_BIT_READBACK];
      O_SCAN_ACTIVE <= scan_on_q;
    end
  end

endmodule : amx_sequencer

// ---- testbench/amx_host_model.sv ----
// host side of the serial configuration port and convert start
// assumes frame is called on a falling clock edge
`timescale 1ns/100ps
module amx_host_model (
  input  wire logic i_clk,
  output logic      o_sck,
  output logic      o_din,
  output logic      o_conv
);
  logic qbw = 1'b0;
  initial begin
    o_sck = 1'b0;
    o_din = 1'b0;
    o_conv = 1'b1;
  end
  task automatic frame(input logic wr, input logic [13:0] w);
    o_conv = 1'b0;
    if (wr) begin
      for (int i = 13; i >= 0; i--) begin
        o_din = w[i];
        repeat (5) @(negedge i_clk);
        o_sck = 1'b1;
        repeat (5) @(negedge i_clk);
        o_sck = 1'b0;
      end
      if (w[13]) qbw = ~w[6];
    end
    o_din = 1'b0;
    repeat (qbw ? 20 : 5) @(negedge i_clk);
    o_conv = 1'b1;
  endtask : frame
endmodule : amx_host_model

// ---- testbench/amx_sequencer_asserts.sv ----
// port checks of the input mux sequencer
// assumes one clock and synchronous active high reset
`timescale 1ns/100ps
module amx_sequencer_asserts
  import amx_pkg::*;
(
  input wire logic        I_CLOCK,
  input wire logic        I_RESET,
  input wire logic        I_SCK,
  input wire logic        I_DIN,
  input wire logic        I_CONVERT,
  input wire logic [15:0] I_RAW_DATA,
  input wire logic        I_RAW_VALID,
  input wire logic [13:0] O_CFG_WORD,
  input wire logic        O_READBACK_EN,
  input wire logic        O_SCAN_ACTIVE,
  input wire amx_mux_t    O_MUX,
  input wire logic        O_CONV_START,
  input wire amx_result_t O_RESULT
);
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (I_RESET);
  sequence s_raw;
    I_RAW_VALID;
  endsequence
  sequence s_conv;
    O_CONV_START && !O_MUX.temp_sensor;
  endsequence
  sequence s_pair;
    s_conv ##0 O_MUX.neg_kind == AMX_NEG_CHANNEL;
  endsequence
  a_result_lat: assert property (s_raw |=> O_RESULT.valid) else $error("late result");
  a_twos_code: assert property (s_raw ##0 O_MUX.bipolar |=> O_RESULT.data == ($past(I_RAW_DATA) ^ 16'h8000))
    else $error("bad twos code");
  a_binary_code: assert property (s_raw ##0 !O_MUX.bipolar |=> O_RESULT.data == $past(I_RAW_DATA))
    else $error("bad binary code");
  a_mux_hold: assert property (!O_CONV_START |-> $stable(O_MUX)) else $error("mux moved");
  a_start_pulse: assert property (O_CONV_START |=> !O_CONV_START) else $error("long start");
  a_bw_select: assert property (s_conv |-> O_MUX.quarter_bw == !O_CFG_WORD[6]) else $error("bad bw");
  a_gnd_single: assert property (s_conv ##0 O_CFG_WORD[12:10] == 3'h7 |-> O_MUX.neg_kind == AMX_NEG_GND)
    else $error("not ground");
  a_sign_mode: assert property (s_conv |-> O_MUX.bipolar == !O_CFG_WORD[12]) else $error("bad sign");
  a_pair_negative: assert property (s_pair |-> O_MUX.neg_ch == (O_MUX.pos_ch ^ 3'h1))
    else $error("bad pair partner");
  a_scan_even: assert property (s_pair ##0 O_SCAN_ACTIVE |-> !O_MUX.pos_ch[0])
    else $error("odd scan pair");
  a_temp_plain: assert property (O_CONV_START && O_MUX.temp_sensor |-> O_MUX.neg_kind == AMX_NEG_GND && !O_MUX.bipolar)
    else $error("bad temp step");
endmodule : amx_sequencer_asserts
bind amx_sequencer amx_sequencer_asserts chk_i (.I_CLOCK(I_CLOCK), .I_RESET(I_RESET), .I_SCK(I_SCK),
  .I_DIN(I_DIN), .I_CONVERT(I_CONVERT), .I_RAW_DATA(I_RAW_DATA), .I_RAW_VALID(I_RAW_VALID), .O_CFG_WORD(O_CFG_WORD),
  .O_READBACK_EN(O_READBACK_EN), .O_SCAN_ACTIVE(O_SCAN_ACTIVE), .O_MUX(O_MUX), .O_CONV_START(O_CONV_START),
  .O_RESULT(O_RESULT));

// ---- testbench/tb_top.sv ----
// self-checking bench of the input mux sequencer
// assumes host model and checker compiled first
`timescale 1ns/100ps
module tb_top;
  import amx_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, sck, din, conv, rv = 1'b0, o_rb, o_scan, o_cs;
  logic [15:0] rd = 16'h0;
  logic [13:0] o_cfg;
  amx_mux_t    o_mux;
  amx_result_t o_res;
  int          n_errors = 0, samples_checked = 0;
  always #4 clk = ~clk;
  amx_host_model host (.i_clk(clk), .o_sck(sck), .o_din(din), .o_conv(conv));
  amx_sequencer uut (.I_CLOCK(clk), .I_RESET(rst), .I_SCK(sck), .I_DIN(din), .I_CONVERT(conv), .I_RAW_DATA(rd),
    .I_RAW_VALID(rv), .O_CFG_WORD(o_cfg), .O_READBACK_EN(o_rb), .O_SCAN_ACTIVE(o_scan), .O_MUX(o_mux),
    .O_CONV_START(o_cs), .O_RESULT(o_res));
  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  function automatic amx_mux_t ex(input logic [13:0] w, input logic [2:0] p);
    ex = '0;
    ex.pos_ch = p;
    ex.neg_ch = p ^ 3'h1;
    ex.neg_kind = (w[12:10] == 3'h7) ? AMX_NEG_GND : (w[11] ? AMX_NEG_COM : AMX_NEG_CHANNEL);
    ex.bipolar = ~w[12];
    ex.quarter_bw = ~w[6];
  endfunction : ex
  // one frame ending in a conversion, then one raw result
  task automatic op(input logic wr, input logic [13:0] w, input logic [2:0] p, input logic tmp);
    amx_mux_t    e;
    logic [15:0] d;
    int          k;
    e = ex(w, p);
    d = 16'($urandom);
    host.frame(wr, w);
    for (k = 0; k < 20 && o_cs !== 1'b1; k++) @(negedge clk);
    if (k == 20) begin
      n_errors++;
      close_out();
    end
    if (tmp) chk(16'(o_mux.temp_sensor), 16'h1);
    else begin
      chk(16'({o_mux.pos_ch, o_mux.neg_kind, o_mux.bipolar, o_mux.quarter_bw, o_mux.temp_sensor}),
          16'({e.pos_ch, e.neg_kind, e.bipolar, e.quarter_bw, 1'b0}));
      if (e.neg_kind == AMX_NEG_CHANNEL) chk(16'(o_mux.neg_ch), 16'(e.neg_ch));
    end
    rd = d;
    rv = 1'b1;
    @(negedge clk);
    rv = 1'b0;
    chk(16'(o_res.valid), 16'h1);
    chk(o_res.data, (!tmp && e.bipolar) ? {~d[15], d[14:0]} : d);
  endtask : op
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [13:0] w;
    void'($urandom(63733));
    repeat (20) @(negedge clk);
    rst = 1'b0;
    repeat (5) @(negedge clk);
    chk(16'(o_cfg), 16'h3fff);
    host.frame(1'b1, 14'h0380);
    repeat (10) @(negedge clk);
    chk(16'(o_cfg), 16'h3fff);
    op(1'b0, 14'h3fff, 3'h7, 1'b0);
    for (int i = 0; i < 8; i++) begin
      w = {1'b1, 3'(i), 3'($urandom), 1'($urandom), 3'($urandom), 2'h0, 1'($urandom)};
      op(1'b1, w, w[9:7], 1'b0);
      chk(16'(o_cfg), 16'(w));
      chk(16'(o_rb), 16'(w[0]));
    end
    chk(16'(o_scan), 16'h0);
    for (int i = 0; i < 5; i++) op(i == 0, 14'h3dfe, 3'(i % 4), 1'b0);
    chk(16'(o_scan), 16'h1);
    op(1'b1, 14'h22fc, 3'h0, 1'b0);
    op(1'b0, 14'h22fc, 3'h2, 1'b0);
    op(1'b0, 14'h22fc, 3'h4, 1'b0);
    op(1'b0, 14'h22fc, 3'h0, 1'b1);
    op(1'b0, 14'h22fc, 3'h0, 1'b0);
    op(1'b1, 14'h3ffe, 3'h0, 1'b0);
    op(1'b0, 14'h3ffe, 3'h1, 1'b0);
    op(1'b1, 14'h3fba, 3'h2, 1'b0);
    chk(16'(o_scan), 16'h1);
    op(1'b1, 14'h3dba, 3'h0, 1'b0);
    op(1'b0, 14'h3dba, 3'h1, 1'b0);
    close_out();
  end
endmodule : tb_top
